//--- rtl/iso_cycle_master.sv
// Bus-side controller of the isochronous cycle: frames, exchange, setpoints
//
// Functional notes
// RL1: Period is n times 250 us, n from 12 to 64; else rejected.
// RL2: Apply instant at least rounded exchange span plus 125 us, below period.
// RL3: Sample instant is 250, 375, 500 or 625 us from cycle start.
// RL4: With apply instant at period minus 125 us, sample at least 375 us.
// RL5: Sample instant never above period, never below one granule.
// RL6: Apply instant not above period, not below exchange span plus granule.
// RL7: Slave period equals the equidistant bus period used by the master.
// RL8: Application cycle runs one to one with the bus cycle.
// RL9: Slave latches positions at sample instant; master gets them next cycle.
// RL10: Slave adopts at apply instant setpoints computed in the previous cycle.
// RL11: Global control frame broadcast each cycle resynchronises the slave.
// RL12: One acyclic service after exchange, only within the token holding limit.
// RL13: Captured value is each axis actual position.
// RL14: Recalculating cyclic component forces 32 ms; period must be re-entered.
// RL15: Slave counts granules from each frame and fires strobes on match.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module iso_cycle_master #(
    parameter int unsigned GRANULE_CYCLES = iso_timing_pkg::GRANULE_CYCLES,
    parameter int unsigned DW             = iso_timing_pkg::DATA_W
) (
    input  wire logic          clk_sys,          // System clock, 125 MHz
    input  wire logic          srst,             // Synchronous reset, active high
    input  wire logic          ce,               // Clock enable, freezes all state
    input  wire logic [5:0]    avs_address,      // Avalon byte address
    input  wire logic          avs_read,         // Avalon read
    input  wire logic          avs_write,        // Avalon write
    input  wire logic [31:0]   avs_writedata,    // Avalon write data
    output logic      [31:0]   avs_readdata,     // Avalon read data
    output logic               avs_waitrequest,  // Avalon wait request
    output logic               gcFrame,          // Global control frame pulse
    output logic               exchangeActive,   // Cyclic data exchange window
    output logic      [DW-1:0] setpointOut,      // Speed setpoint to slave
    input  wire logic [DW-1:0] actPosIn,         // Actual position from slave
    input  wire logic          actPosValid,      // Position word present
    output logic               acyclicReq,       // Acyclic service pulse
    output logic               busRunning        // Equidistant cycle running
);
    cycle_if cy ();

    // Configuration and state
    logic [1:0]    ctrl_reg;
    logic [7:0]    periodN_reg;
    logic [3:0]    sampleU_reg;
    logic [8:0]    applyU_reg;
    logic [15:0]   spanUs_reg;
    logic [8:0]    tokenLim_reg;
    logic [DW-1:0] setpoint_reg;
    logic [DW-1:0] actPos_reg;
    logic [31:0]   cycles_reg;
    logic          reentry_reg;
    logic          acycPend_reg;
    logic          exchDone_reg;
    logic          acycUsed_reg;
    logic          wait_reg;
    logic [31:0]   rdata_reg;
    logic          run_reg;
    logic          gc_reg;
    logic          exch_reg;
    logic [DW-1:0] spOut_reg;
    logic          acyc_reg;

    logic [9:0]    spanU;
    logic          periodOk;
    logic          sampleOk;
    logic          applyOk;

    iso_param_check u_check (
        .periodN  (periodN_reg),
        .sampleU  (sampleU_reg),
        .applyU   (applyU_reg),
        .spanUs   (spanUs_reg),
        .spanU    (spanU),
        .periodOk (periodOk),
        .sampleOk (sampleOk),
        .applyOk  (applyOk)
    );

    cycle_timer #(
        .GRANULE_CYCLES (GRANULE_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .cy      (cy)
    );

    // Bus period and slave check share one register
    assign cy.periodUnits = {periodN_reg, 1'b0};  // [RL7]
    assign cy.run         = run_reg;

    wire configValid = periodOk && sampleOk && applyOk && !reentry_reg;

    // Avalon decode
    wire busReq  = (avs_read || avs_write) && wait_reg;
    wire wrStb   = avs_write && !wait_reg;
    wire wrCtrl  = wrStb && (avs_address == iso_timing_pkg::OFF_CTRL);
    wire wrPer   = wrStb && (avs_address == iso_timing_pkg::OFF_PERIOD);
    wire wrSamp  = wrStb && (avs_address == iso_timing_pkg::OFF_SAMPLE);
    wire wrApply = wrStb && (avs_address == iso_timing_pkg::OFF_APPLY);
    wire wrSpan  = wrStb && (avs_address == iso_timing_pkg::OFF_SPAN);
    wire wrToken = wrStb && (avs_address == iso_timing_pkg::OFF_TOKEN);
    wire wrSetp  = wrStb && (avs_address == iso_timing_pkg::OFF_SETPOINT);
    wire acycSet = wrCtrl && avs_writedata[iso_timing_pkg::CTRL_ACYCLIC_BIT];

    wire [31:0] statusWord = {25'h0000000, acycPend_reg, run_reg, reentry_reg,
                              !sampleOk, !applyOk, !periodOk, configValid};

    wire [31:0] rdMux =
        (avs_address == iso_timing_pkg::OFF_CTRL)     ? 32'(ctrl_reg) :
        (avs_address == iso_timing_pkg::OFF_STATUS)   ? statusWord :
        (avs_address == iso_timing_pkg::OFF_PERIOD)   ? 32'(periodN_reg) :
        (avs_address == iso_timing_pkg::OFF_SAMPLE)   ? 32'(sampleU_reg) :
        (avs_address == iso_timing_pkg::OFF_APPLY)    ? 32'(applyU_reg) :
        (avs_address == iso_timing_pkg::OFF_SPAN)     ? 32'(spanUs_reg) :
        (avs_address == iso_timing_pkg::OFF_TOKEN)    ? 32'(tokenLim_reg) :
        (avs_address == iso_timing_pkg::OFF_SETPOINT) ? 32'(setpoint_reg) :
        (avs_address == iso_timing_pkg::OFF_ACTPOS)   ? 32'(actPos_reg) :
        (avs_address == iso_timing_pkg::OFF_CYCLES)   ? cycles_reg :
        32'h00000000;

    // Cycle events
    wire [9:0] spanEndU  = (spanU == 10'h000) ? 10'h001 : spanU;
    wire       exchEnd   = exch_reg && cy.tick && ({1'b0, cy.granule} >= spanEndU);
    wire       tokenLeft = cy.granule < tokenLim_reg;
    // Never on a cycle start edge: the service must follow this cycle's exchange
    wire       acycFire  = run_reg && exchDone_reg && !acycUsed_reg && acycPend_reg && tokenLeft && !cy.cycleStart;

    // Bus slave: one wait cycle, then a single answer cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else if (ce) begin
            wait_reg <= !busReq;
            if (busReq && avs_read) begin
                rdata_reg <= rdMux;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_reg     <= 2'b00;
            periodN_reg  <= iso_timing_pkg::PERIOD_RST;
            sampleU_reg  <= iso_timing_pkg::SAMPLE_RST;
            applyU_reg   <= iso_timing_pkg::APPLY_RST;
            spanUs_reg   <= iso_timing_pkg::SPAN_RST;
            tokenLim_reg <= iso_timing_pkg::TOKEN_RST;
            setpoint_reg <= '0;
            reentry_reg  <= 1'b0;
        end else if (ce) begin
            if (wrCtrl) begin
                ctrl_reg <= {1'b0, avs_writedata[iso_timing_pkg::CTRL_ENABLE_BIT]};
            end
            if (wrSpan) begin
                // New cyclic component: period forced to 32 ms until re-entered
                spanUs_reg  <= avs_writedata[15:0];
                periodN_reg <= iso_timing_pkg::PERIOD_N_RECALC;  // [RL14]
                reentry_reg <= 1'b1;  // [RL14]
            end else if (wrPer) begin
                periodN_reg <= avs_writedata[7:0];
                reentry_reg <= 1'b0;  // [RL14]
            end
            if (wrSamp) begin
                sampleU_reg <= avs_writedata[3:0];
            end
            if (wrApply) begin
                applyU_reg <= avs_writedata[8:0];
            end
            if (wrToken) begin
                tokenLim_reg <= avs_writedata[8:0];
            end
            if (wrSetp) begin
                setpoint_reg <= avs_writedata[DW-1:0];
            end
        end
    end

    // Run only on a checked setup; a bad write stops frames at once
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            run_reg <= 1'b0;
        end else if (ce) begin
            run_reg <= ctrl_reg[iso_timing_pkg::CTRL_ENABLE_BIT] && configValid;  // [RL1] [RL2] [RL3] [RL4]
        end
    end

    // Frame, exchange window and setpoint handover
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gc_reg       <= 1'b0;
            exch_reg     <= 1'b0;
            exchDone_reg <= 1'b0;
            spOut_reg    <= '0;
            cycles_reg   <= '0;
        end else if (ce) begin
            gc_reg <= run_reg && cy.cycleStart;  // [RL11]
            if (!run_reg) begin
                exch_reg     <= 1'b0;
                exchDone_reg <= 1'b0;
            end else if (cy.cycleStart) begin
                exch_reg     <= 1'b1;
                exchDone_reg <= 1'b0;
                // Setpoint computed during the cycle just ended, one per cycle
                spOut_reg    <= setpoint_reg;  // [RL8] [RL10]
                cycles_reg   <= cycles_reg + 32'h00000001;
            end else if (exchEnd) begin
                exch_reg     <= 1'b0;
                exchDone_reg <= 1'b1;
            end
        end
    end

    // Positions arriving now were sampled by the slave in the previous cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            actPos_reg <= '0;
        end else if (ce && exch_reg && actPosValid) begin
            actPos_reg <= actPosIn;  // [RL9] [RL13]
        end
    end

    // Acyclic service: at most one per cycle, after exchange, within the limit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            acycPend_reg <= 1'b0;
            acycUsed_reg <= 1'b0;
            acyc_reg     <= 1'b0;
        end else if (ce) begin
            acyc_reg     <= acycFire;  // [RL12]
            // A new request in the issue cycle stays pending
            acycPend_reg <= acycSet || (acycPend_reg && !acycFire);
            if (cy.cycleStart || !run_reg) begin
                acycUsed_reg <= 1'b0;
            end else if (acycFire) begin
                acycUsed_reg <= 1'b1;  // [RL12]
            end
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;
    assign gcFrame         = gc_reg;
    assign exchangeActive  = exch_reg;
    assign setpointOut     = spOut_reg;
    assign acyclicReq      = acyc_reg;
    assign busRunning      = run_reg;
endmodule

//--- shared/iso_timing_pkg.sv
// Constants shared by the isochronous cycle controller
package iso_timing_pkg;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int GRANULE_US     = 125;
    // Cycles per granule, rounded down
    localparam int GRANULE_CYCLES = (GRANULE_US * 1000) / CLK_PERIOD_NS;
    localparam int GRANULE_W      = 9;
    localparam int DATA_W         = 32;

    // Period is kept as n, in 250 us steps (two granules each)
    localparam logic [7:0] PERIOD_N_MIN    = 8'h0c;
    localparam logic [7:0] PERIOD_N_MAX    = 8'h40;
    localparam logic [7:0] PERIOD_N_RECALC = 8'h80;
    // Sample instant in granules: 250, 375, 500 or 625 us
    localparam logic [3:0] SAMPLE_U_MIN    = 4'h2;
    localparam logic [3:0] SAMPLE_U_MAX    = 4'h5;
    localparam logic [3:0] SAMPLE_U_AT_MAX = 4'h3;
    localparam logic [3:0] APPLY_GAP_U     = 4'h1;
    localparam logic [7:0] SPAN_ROUND_ADD  = 8'h7c;

    // Register byte addresses
    localparam logic [5:0] OFF_CTRL     = 6'h00;
    localparam logic [5:0] OFF_STATUS   = 6'h04;
    localparam logic [5:0] OFF_PERIOD   = 6'h08;
    localparam logic [5:0] OFF_SAMPLE   = 6'h0c;
    localparam logic [5:0] OFF_APPLY    = 6'h10;
    localparam logic [5:0] OFF_SPAN     = 6'h14;
    localparam logic [5:0] OFF_TOKEN    = 6'h18;
    localparam logic [5:0] OFF_SETPOINT = 6'h1c;
    localparam logic [5:0] OFF_ACTPOS   = 6'h20;
    localparam logic [5:0] OFF_CYCLES   = 6'h24;

    // Field positions
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_ACYCLIC_BIT = 1;
    localparam int ST_VALID_BIT     = 0;
    localparam int ST_PERIOD_BAD    = 1;
    localparam int ST_APPLY_BAD     = 2;
    localparam int ST_SAMPLE_BAD    = 3;
    localparam int ST_REENTRY_BIT   = 4;
    localparam int ST_RUNNING_BIT   = 5;
    localparam int ST_ACYC_PEND_BIT = 6;

    // Reset values: a legal 3 ms setup
    localparam logic [7:0]  PERIOD_RST = 8'h0c;
    localparam logic [3:0]  SAMPLE_RST = 4'h2;
    localparam logic [8:0]  APPLY_RST  = 9'h00a;
    localparam logic [15:0] SPAN_RST   = 16'h0000;
    localparam logic [8:0]  TOKEN_RST  = 9'h1ff;
endpackage

//--- shared/cycle_if.sv
// Cycle timing signals between controller and granule timer
`timescale 1ns/10ps
interface cycle_if;
    logic                                  run;
    logic [iso_timing_pkg::GRANULE_W-1:0]  periodUnits;
    logic                                  tick;
    logic [iso_timing_pkg::GRANULE_W-1:0]  granule;
    logic                                  cycleStart;

    modport timer (input run, input periodUnits, output tick, output granule, output cycleStart);
    modport user  (output run, output periodUnits, input tick, input granule, input cycleStart);
endinterface

//--- rtl/cycle_timer.sv
// Granule tick generator and position counter inside the bus cycle
`timescale 1ns/10ps
module cycle_timer #(
    parameter int unsigned GRANULE_CYCLES = iso_timing_pkg::GRANULE_CYCLES
) (
    input  wire logic clk_sys,  // System clock
    input  wire logic srst,     // Synchronous reset
    input  wire logic ce,       // Clock enable
    cycle_if.timer    cy        // Timing to controller
);
    localparam int CW = $clog2(GRANULE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(GRANULE_CYCLES - 1);

    logic [CW-1:0] tickCnt_reg;
    logic          started_reg;
    wire           lastGranule = (cy.granule == cy.periodUnits - 9'h001);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tickCnt_reg   <= '0;
            started_reg   <= 1'b0;
            cy.tick       <= 1'b0;
            cy.granule    <= '0;
            cy.cycleStart <= 1'b0;
        end else if (ce) begin
            cy.tick       <= 1'b0;
            cy.cycleStart <= 1'b0;
            if (!cy.run) begin
                tickCnt_reg <= '0;
                started_reg <= 1'b0;
                cy.granule  <= '0;
            end else if (!started_reg) begin
                // First frame goes out as soon as the bus starts
                started_reg   <= 1'b1;
                cy.cycleStart <= 1'b1;
            end else if (tickCnt_reg == LAST) begin
                tickCnt_reg <= '0;
                cy.tick     <= 1'b1;  // [RL15]
                if (lastGranule) begin
                    cy.granule    <= '0;
                    cy.cycleStart <= 1'b1;
                end else begin
                    cy.granule <= cy.granule + 9'h001;
                end
            end else begin
                tickCnt_reg <= tickCnt_reg + CW'(1);
            end
        end
    end
endmodule

//--- rtl/iso_param_check.sv
// Range checks of period, sample instant and apply instant
`timescale 1ns/10ps
module iso_param_check (
    input  wire logic [7:0]  periodN,   // Period in 250 us steps
    input  wire logic [3:0]  sampleU,   // Sample instant in granules
    input  wire logic [8:0]  applyU,    // Apply instant in granules
    input  wire logic [15:0] spanUs,    // Data exchange span in us
    output logic [9:0]       spanU,     // Span rounded up to granules
    output logic             periodOk,  // Period legal
    output logic             sampleOk,  // Sample instant legal
    output logic             applyOk    // Apply instant legal
);
    function automatic logic [9:0] roundUpGranules(input logic [15:0] us);
        logic [16:0] sum;
        sum = {1'b0, us} + {9'h000, iso_timing_pkg::SPAN_ROUND_ADD};
        roundUpGranules = 10'(sum / 17'd125);
    endfunction

    wire [9:0]  periodG = {1'b0, periodN, 1'b0};
    wire [10:0] applyMin = {1'b0, spanU} + {7'h00, iso_timing_pkg::APPLY_GAP_U};
    wire        applyAtMax = ({1'b0, applyU} == periodG - 10'h001);

    assign spanU    = roundUpGranules(spanUs);
    assign periodOk = (periodN >= iso_timing_pkg::PERIOD_N_MIN) &&
                      (periodN <= iso_timing_pkg::PERIOD_N_MAX);  // [RL1]
    assign sampleOk = (sampleU >= iso_timing_pkg::SAMPLE_U_MIN) &&
                      (sampleU <= iso_timing_pkg::SAMPLE_U_MAX) &&
                      ({6'h00, sampleU} <= periodG) &&  // [RL3] [RL5]
                      (!applyAtMax || sampleU >= iso_timing_pkg::SAMPLE_U_AT_MAX);  // [RL4]
    assign applyOk  = ({2'b00, applyU} >= applyMin) &&
                      ({1'b0, applyU} < periodG);  // [RL2] [RL6]
endmodule

//--- verif/iso_cycle_master_asserts.sv
// Port-level assertions for the isochronous cycle controller
`timescale 1ns/10ps
module iso_cycle_master_asserts #(
    parameter int unsigned GRANULE_CYCLES = iso_timing_pkg::GRANULE_CYCLES,
    parameter int unsigned DW             = iso_timing_pkg::DATA_W
) (
    input wire logic          clk_sys,         // Clock
    input wire logic          srst,            // Reset
    input wire logic          ce,              // Enable
    input wire logic          avs_read,        // Read
    input wire logic          avs_write,       // Write
    input wire logic          avs_waitrequest, // Wait
    input wire logic          gcFrame,         // Frame pulse
    input wire logic          exchangeActive,  // Exchange window
    input wire logic [DW-1:0] setpointOut,     // Setpoint
    input wire logic          acyclicReq,      // Acyclic pulse
    input wire logic          busRunning       // Running
);
    localparam int STEP = 2 * GRANULE_CYCLES;
    logic [31:0] gapReg;
    logic        seenReg;
    // Gap only judged between two frames of one run
    always_ff @(posedge clk_sys) begin
        if (srst || !busRunning) begin
            gapReg  <= '0;
            seenReg <= 1'b0;
        end else if (ce) begin
            gapReg  <= gcFrame ? 32'h1 : gapReg + 32'h1;
            seenReg <= seenReg | gcFrame;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_req; (avs_read || avs_write) && avs_waitrequest && ce; endsequence
    sequence s_run; $rose(busRunning); endsequence
    property p_answer; s_req |=> !avs_waitrequest; endproperty
    property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_wait_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
    property p_first_frame; s_run |-> ##2 (gcFrame && exchangeActive); endproperty
    property p_gc_pulse; gcFrame |-> busRunning ##1 !gcFrame; endproperty
    property p_exch_open; $rose(exchangeActive) |-> gcFrame; endproperty
    property p_sp_hold; !gcFrame && !$past(gcFrame) |-> $stable(setpointOut); endproperty
    property p_acyc; acyclicReq |-> (busRunning && !exchangeActive) ##1 !acyclicReq; endproperty
    property p_period;
        gcFrame && seenReg |-> (gapReg % STEP) == 0 && gapReg >= 24 * GRANULE_CYCLES && gapReg <= 128 * GRANULE_CYCLES;
    endproperty
    property p_reset;
        disable iff (1'b0) srst |=> avs_waitrequest && !gcFrame && !busRunning && !acyclicReq && !exchangeActive;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after request");
    a_wait_pulse: assert property (p_wait_pulse) else $error("wait low longer than one cycle");
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    a_first_frame: assert property (p_first_frame) else $error("first frame late");
    a_gc_pulse: assert property (p_gc_pulse) else $error("frame pulse wrong");
    a_exch_open: assert property (p_exch_open) else $error("exchange opened without frame");
    a_sp_hold: assert property (p_sp_hold) else $error("setpoint moved mid cycle");
    a_acyc: assert property (p_acyc) else $error("acyclic service misplaced");
    a_period: assert property (p_period) else $error("frame spacing illegal");
    a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule
bind iso_cycle_master iso_cycle_master_asserts #(.GRANULE_CYCLES(GRANULE_CYCLES), .DW(DW)) u_chk (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .gcFrame(gcFrame), .exchangeActive(exchangeActive),
    .setpointOut(setpointOut), .acyclicReq(acyclicReq), .busRunning(busRunning));

//--- verif/iso_slave_model.sv
// Behavioural isochronous drive slave facing the cycle controller
`timescale 1ns/10ps
module iso_slave_model #(
    parameter int unsigned GRANULE_CYCLES = 4
) (
    input  wire logic        clk_sys,        // Clock
    input  wire logic        srst,           // Reset
    input  wire logic        gcFrame,        // Frame pulse
    input  wire logic        exchangeActive, // Exchange window
    input  wire logic [31:0] setpointOut,    // Setpoint
    input  wire logic [3:0]  sampleU,        // Sample instant
    input  wire logic [8:0]  applyU,         // Apply instant
    output logic      [31:0] actPosIn,       // Position word
    output logic             actPosValid,    // Position valid
    output logic      [31:0] sentPos,        // Position sent this cycle
    output logic      [31:0] appliedSp       // Setpoint in force
);
    logic [15:0] tickCnt;
    logic [8:0]  granCnt;
    logic [31:0] posCnt;
    logic [31:0] latched;
    logic        onGrain;
    assign onGrain = (tickCnt == 16'h0000);
    always @(posedge clk_sys) begin
        posCnt <= srst ? 32'h1000_0000 : posCnt + 32'h0000_0003;
        if (srst) begin
            tickCnt   <= 16'h0000;
            granCnt   <= 9'h000;
            sentPos   <= 32'h0000_0000;
            latched   <= 32'h0000_0000;
            appliedSp <= 32'h0000_0000;
        end else if (gcFrame) begin
            tickCnt <= 16'h0000;
            granCnt <= 9'h000;
            sentPos <= latched;
        end else if (tickCnt == 16'(GRANULE_CYCLES - 1)) begin
            tickCnt <= 16'h0000;
            granCnt <= granCnt + 9'h001;
        end else begin
            tickCnt <= tickCnt + 16'h0001;
        end
        if (!srst && !gcFrame && onGrain && granCnt == {5'h00, sampleU}) begin
            latched <= posCnt;
        end
        if (!srst && !gcFrame && onGrain && granCnt == applyU) begin
            appliedSp <= setpointOut;
        end
    end
    // Outside the window the word is scrambled, not held
    assign actPosValid = exchangeActive && !gcFrame;
    assign actPosIn    = actPosValid ? sentPos : ~sentPos;
endmodule

//--- verif/tb.sv
// Self-checking bench for the isochronous cycle controller
`timescale 1ns/10ps
`define CHK(gotV, expV) begin compares++; if ((gotV) !== (expV)) begin errorCnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, gotV, expV); end end
module tb;
    localparam int G = 4;
    logic        clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, setpointOut, actPosIn, sentPos, appliedSp, sp;
    logic        avs_waitrequest, gcFrame, exchangeActive, actPosValid, acyclicReq, busRunning;
    logic [3:0]  samp = 4'h2;
    logic [8:0]  app = 9'h00a;
    logic [63:0] expQ[$];
    logic [63:0] ent;
    int          errorCnt = 0, compares = 0, frameCnt = 0, acycCnt = 0, a0, f0;
    logic [31:0] rstT[8] = '{32'h00000000, 32'h04000001, 32'h0800000c, 32'h0c000002,
                             32'h1000000a, 32'h14000000, 32'h180001ff, 32'h28000000};
    logic [31:0] cfgT[12] = '{32'h0c200a1f, 32'h0b200a2f, 32'h40200a1f, 32'h41200a2f, 32'h0c100a8f, 32'h0c500a1f,
                              32'h0c600a8f, 32'h0c201701, 32'h0c30171f, 32'h0c20184f, 32'h0c20011f, 32'h0c20004f};
    always #4 clk_sys = ~clk_sys;
    iso_cycle_master #(.GRANULE_CYCLES(G)) u_dut (
        .clk_sys(clk_sys), .srst(srst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .gcFrame(gcFrame), .exchangeActive(exchangeActive),
        .setpointOut(setpointOut), .actPosIn(actPosIn), .actPosValid(actPosValid),
        .acyclicReq(acyclicReq), .busRunning(busRunning));
    iso_slave_model #(.GRANULE_CYCLES(G)) u_slave (
        .clk_sys(clk_sys), .srst(srst), .gcFrame(gcFrame), .exchangeActive(exchangeActive),
        .setpointOut(setpointOut), .sampleU(samp), .applyU(app), .actPosIn(actPosIn),
        .actPosValid(actPosValid), .sentPos(sentPos), .appliedSp(appliedSp));
    task automatic busOp(input bit wr, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m);
        int n = 0;
        @(posedge clk_sys);
        if (!wr) begin
            expQ.push_back({m, d});
        end
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic waitFrames(input int k);
        repeat (k) begin
            @(posedge clk_sys);
            while (gcFrame !== 1'b1) @(posedge clk_sys);
        end
    endtask
    task automatic printVerdict();
        $display("compares %0d errors %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Each completed read takes the oldest note
    always @(posedge clk_sys) begin
        if (gcFrame === 1'b1) frameCnt++;
        if (acyclicReq === 1'b1) acycCnt++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            ent = expQ.pop_front();
            `CHK(avs_readdata & ent[63:32], ent[31:0])
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errorCnt++;
        printVerdict();
    end
    initial begin
        void'($urandom(34608));
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        busOp(1, 6'h28, $urandom, 32'h0);
        for (int i = 0; i < 8; i++) busOp(0, rstT[i][29:24], {8'h00, rstT[i][23:0]}, 32'hffff_ffff);
        for (int i = 0; i < 12; i++) begin
            busOp(1, iso_timing_pkg::OFF_PERIOD, {24'h0, cfgT[i][31:24]}, 32'h0);
            busOp(1, iso_timing_pkg::OFF_SAMPLE, {28'h0, cfgT[i][23:20]}, 32'h0);
            busOp(1, iso_timing_pkg::OFF_APPLY, {20'h0, cfgT[i][19:8]}, 32'h0);
            busOp(0, iso_timing_pkg::OFF_STATUS, {28'h0, cfgT[i][7:4]}, {28'h0, cfgT[i][3:0]});
        end
        // Span of 300 us rounds to three granules
        busOp(1, iso_timing_pkg::OFF_SPAN, 32'h0000_012c, 32'h0);
        busOp(0, iso_timing_pkg::OFF_PERIOD, 32'h0000_0080, 32'hffff_ffff);
        busOp(0, iso_timing_pkg::OFF_STATUS, 32'h0000_0010, 32'h0000_0011);
        busOp(1, iso_timing_pkg::OFF_PERIOD, 32'h0000_000c, 32'h0);
        busOp(1, iso_timing_pkg::OFF_APPLY, 32'h0000_0003, 32'h0);
        busOp(0, iso_timing_pkg::OFF_STATUS, 32'h0000_0004, 32'h0000_0017);
        samp = 4'h2 + 4'($urandom % 4);
        app  = 9'h004 + 9'($urandom % 19);
        sp   = $urandom;
        busOp(1, iso_timing_pkg::OFF_SAMPLE, {28'h0, samp}, 32'h0);
        busOp(1, iso_timing_pkg::OFF_APPLY, {23'h0, app}, 32'h0);
        busOp(1, iso_timing_pkg::OFF_SETPOINT, sp, 32'h0);
        busOp(1, iso_timing_pkg::OFF_CTRL, 32'h0000_0001, 32'h0);
        waitFrames(3);
        `CHK(setpointOut, sp)
        `CHK(appliedSp, sp)
        repeat (40) @(posedge clk_sys);
        busOp(0, iso_timing_pkg::OFF_ACTPOS, sentPos, 32'hffff_ffff);
        busOp(0, iso_timing_pkg::OFF_STATUS, 32'h0000_0021, 32'h0000_002f);
        a0 = acycCnt;
        busOp(1, iso_timing_pkg::OFF_CTRL, 32'h0000_0003, 32'h0);
        waitFrames(3);
        `CHK(acycCnt - a0, 1)
        busOp(1, iso_timing_pkg::OFF_TOKEN, 32'h0000_0000, 32'h0);
        a0 = acycCnt;
        busOp(1, iso_timing_pkg::OFF_CTRL, 32'h0000_0003, 32'h0);
        waitFrames(3);
        `CHK(acycCnt - a0, 0)
        busOp(0, iso_timing_pkg::OFF_STATUS, 32'h0000_0040, 32'h0000_0040);
        busOp(1, iso_timing_pkg::OFF_PERIOD, 32'h0000_0041, 32'h0);
        repeat (4) @(posedge clk_sys);
        `CHK(busRunning, 1'b0)
        f0 = frameCnt;
        repeat (300) @(posedge clk_sys);
        `CHK(frameCnt - f0, 0)
        printVerdict();
    end
endmodule
